// file: src/calendar_access_and_alarm.sv
// access interlock of the time counters, alarm registers, alarm flag and interrupt
//
// Notes on behaviour
// - counters 03h..09h do not step while a host transfer is active
// - at transfer end the counters step once for a held tick; extras lost
// - minute alarm 0Ah: bit7 disable, bcd tens 6..4, units 3..0
// - hour alarm 0Bh: bit7 disable, bit6 unused, layout follows hour format
// - day alarm 0Ch: bit7 disable, bit6 unused, bcd day in 5..0
// - weekday alarm 0Dh: bit7 disable, bits 6..3 unused, code in 2..0
// - enabled fields compared with time; flag set when all first match
// - flag sticks until cleared; sets again only on a fresh match
// - flag register: watchdog 7, countdown a 6, countdown b 5, second 4, alarm 3
// - host write to flag bits is anded: zero clears, one keeps
// - with irq enable set, first interrupt output follows the alarm flag
// - alarm interrupt is a level only, never a pulse
`timescale 1ns/100ps
`default_nettype none
module calendar_access_and_alarm
  import cal_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // one second tick, one cycle pulse
  input wire logic i_sec_tick,
  // host transfer from the serial slave
  input wire logic i_xfer_active,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // control bits held elsewhere
  input wire logic i_hour_12_mode,
  input wire logic i_alarm_irq_enable,
  // flag set events from neighbouring units
  input wire logic i_watchdog_timer_set,
  input wire logic i_countdown_a_set,
  input wire logic i_countdown_b_set,
  input wire logic i_second_tick_set,
  // open drain interrupt pin, active low
  output logic o_irq_out_first_o,
  output logic o_irq_out_first_oe,
  // state for neighbouring units
  output time_t o_time,
  output logic [7:0] o_flag_status,
  output logic o_tick_pending
);

  logic tick_pending_q, tick_pending_d;
  logic advance;
  logic advanced_q;
  logic match;
  logic match_prev_q;
  logic [7:0] alarm_minute_setting_q;
  logic [7:0] alarm_hour_setting_q;
  logic [7:0] alarm_day_setting_q;
  logic [7:0] alarm_weekday_setting_q;
  logic [7:0] flag_status_register_q, flag_status_register_d;
  logic [7:0] flag_set;
  logic [7:0] flag_keep;
  logic [7:0] rd_data_q;
  logic alarm_set;
  logic flag_wr;
  time_t cur_time;

  // step only outside a transfer, either for a fresh tick or a held one
  assign advance = !i_xfer_active && (i_sec_tick || tick_pending_q);

  // one held tick at most; a second tick inside the same transfer is dropped
  always_comb begin
    tick_pending_d = tick_pending_q;
    if (i_xfer_active) begin
      if (i_sec_tick) begin
        tick_pending_d = 1'b1;
      end
    end else begin
      tick_pending_d = 1'b0;
    end
  end

  // held tick register
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      tick_pending_q <= 1'b0;
    end else begin
      tick_pending_q <= tick_pending_d;
    end
  end

  // the counters themselves
  time_counter u_time_counter (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_advance(advance),
    .i_hour_12_mode(i_hour_12_mode),
    .i_wr_en(i_wr_en),
    .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data),
    .o_time(cur_time)
  );

  // alarm settings, writes keep only the implemented bits
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      alarm_minute_setting_q <= ALARM_RESET;
      alarm_hour_setting_q <= ALARM_RESET;
      alarm_day_setting_q <= ALARM_RESET;
      alarm_weekday_setting_q <= ALARM_RESET;
    end else if (i_wr_en) begin
      case (i_wr_addr)
        ADDR_ALARM_MINUTE: alarm_minute_setting_q <= i_wr_data & MASK_ALARM_MINUTE;
        ADDR_ALARM_HOUR: alarm_hour_setting_q <= i_wr_data & MASK_ALARM_HOUR;
        ADDR_ALARM_DAY: alarm_day_setting_q <= i_wr_data & MASK_ALARM_DAY;
        ADDR_ALARM_WEEKDAY: alarm_weekday_setting_q <= i_wr_data & MASK_ALARM_WEEKDAY;
        default: alarm_minute_setting_q <= alarm_minute_setting_q;
      endcase
    end
  end

  // comparator on the current counter value
  alarm_match u_alarm_match (
    .i_alarm_minute(alarm_minute_setting_q),
    .i_alarm_hour(alarm_hour_setting_q),
    .i_alarm_day(alarm_day_setting_q),
    .i_alarm_weekday(alarm_weekday_setting_q),
    .i_time(cur_time),
    .o_match(match)
  );

  // marks the cycle after a step, when the counters hold the new time
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      advanced_q <= 1'b0;
    end else begin
      advanced_q <= advance;
    end
  end

  // match history sampled only after steps, so host writes never create a match
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      match_prev_q <= 1'b0;
    end else if (advanced_q) begin
      match_prev_q <= match;
    end
  end

  // a rising match seen after a step; a match that merely persists does nothing
  assign alarm_set = advanced_q && match && !match_prev_q;

  // flag set pulses in register layout
  always_comb begin
    flag_set = 8'h00;
    flag_set[WATCHDOG_FLAG_BIT] = i_watchdog_timer_set;
    flag_set[COUNTDOWN_A_FLAG_BIT] = i_countdown_a_set;
    flag_set[COUNTDOWN_B_FLAG_BIT] = i_countdown_b_set;
    flag_set[SECOND_FLAG_BIT] = i_second_tick_set;
    flag_set[ALARM_FLAG_BIT] = alarm_set;
  end

  assign flag_wr = i_wr_en && (i_wr_addr == ADDR_FLAG_STATUS);

  // flags are anded with the write, settings bits load; an event in the clear cycle wins
  always_comb begin
    flag_keep = flag_wr ? (i_wr_data | ~FLAG_BITS_MASK) : 8'hff;
    flag_status_register_d = ((flag_status_register_q & flag_keep & FLAG_BITS_MASK)
                              | flag_set);
    if (flag_wr) begin
      // plain rewrite of the same settings changes nothing
      flag_status_register_d = flag_status_register_d
                               | (i_wr_data & SETTING_BITS_MASK);
    end else begin
      flag_status_register_d = flag_status_register_d
                               | (flag_status_register_q & SETTING_BITS_MASK);
    end
  end

  // flag and status register
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      flag_status_register_q <= FLAG_STATUS_RESET;
    end else begin
      flag_status_register_q <= flag_status_register_d;
    end
  end

  // read data is registered; unmapped addresses read zero
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rd_data_q <= 8'h00;
    end else if (i_rd_en) begin
      case (i_rd_addr)
        ADDR_SECONDS: rd_data_q <= cur_time.seconds;
        ADDR_MINUTES: rd_data_q <= cur_time.minutes;
        ADDR_HOURS: rd_data_q <= cur_time.hours;
        ADDR_DAYS: rd_data_q <= cur_time.days;
        ADDR_WEEKDAYS: rd_data_q <= cur_time.weekdays;
        ADDR_MONTHS: rd_data_q <= cur_time.months;
        ADDR_YEARS: rd_data_q <= cur_time.years;
        ADDR_ALARM_MINUTE: rd_data_q <= alarm_minute_setting_q;
        ADDR_ALARM_HOUR: rd_data_q <= alarm_hour_setting_q;
        ADDR_ALARM_DAY: rd_data_q <= alarm_day_setting_q;
        ADDR_ALARM_WEEKDAY: rd_data_q <= alarm_weekday_setting_q;
        ADDR_FLAG_STATUS: rd_data_q <= flag_status_register_q;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  // level interrupt straight from the flag, so a clear releases the pin at once
  // the pin is only ever pulled low; it floats high when released
  assign o_irq_out_first_oe = i_alarm_irq_enable
                              && flag_status_register_q[ALARM_FLAG_BIT];
  assign o_irq_out_first_o = 1'b0;

  assign o_rd_data = rd_data_q;
  assign o_time = cur_time;
  assign o_flag_status = flag_status_register_q;
  assign o_tick_pending = tick_pending_q;

endmodule
`default_nettype wire

// file: src/cal_pkg.sv
// shared constants, time record type and bcd helpers for the calendar block
package cal_pkg;

  // register addresses
  localparam logic [7:0] ADDR_SECONDS = 8'h03;
  localparam logic [7:0] ADDR_MINUTES = 8'h04;
  localparam logic [7:0] ADDR_HOURS = 8'h05;
  localparam logic [7:0] ADDR_DAYS = 8'h06;
  localparam logic [7:0] ADDR_WEEKDAYS = 8'h07;
  localparam logic [7:0] ADDR_MONTHS = 8'h08;
  localparam logic [7:0] ADDR_YEARS = 8'h09;
  localparam logic [7:0] ADDR_ALARM_MINUTE = 8'h0a;
  localparam logic [7:0] ADDR_ALARM_HOUR = 8'h0b;
  localparam logic [7:0] ADDR_ALARM_DAY = 8'h0c;
  localparam logic [7:0] ADDR_ALARM_WEEKDAY = 8'h0d;
  localparam logic [7:0] ADDR_FLAG_STATUS = 8'h01;

  // implemented bits of each time register
  localparam logic [7:0] MASK_SECONDS = 8'h7f;
  localparam logic [7:0] MASK_MINUTES = 8'h7f;
  localparam logic [7:0] MASK_HOURS = 8'h3f;
  localparam logic [7:0] MASK_DAYS = 8'h3f;
  localparam logic [7:0] MASK_WEEKDAYS = 8'h07;
  localparam logic [7:0] MASK_MONTHS = 8'h1f;
  localparam logic [7:0] MASK_YEARS = 8'hff;

  // implemented bits of the alarm registers
  localparam logic [7:0] MASK_ALARM_MINUTE = 8'hff;
  localparam logic [7:0] MASK_ALARM_HOUR = 8'hbf;
  localparam logic [7:0] MASK_ALARM_DAY = 8'hbf;
  localparam logic [7:0] MASK_ALARM_WEEKDAY = 8'h87;

  // field positions
  localparam int MATCH_DISABLE_BIT = 7;
  localparam int AFTERNOON_BIT = 5;
  localparam int WATCHDOG_FLAG_BIT = 7;
  localparam int COUNTDOWN_A_FLAG_BIT = 6;
  localparam int COUNTDOWN_B_FLAG_BIT = 5;
  localparam int SECOND_FLAG_BIT = 4;
  localparam int ALARM_FLAG_BIT = 3;
  localparam logic [7:0] FLAG_BITS_MASK = 8'hf8;
  localparam logic [7:0] SETTING_BITS_MASK = 8'h07;

  // reset values
  localparam logic [7:0] ALARM_RESET = 8'h80;
  localparam logic [7:0] FLAG_STATUS_RESET = 8'h00;
  localparam logic [7:0] TIME_ZERO = 8'h00;
  localparam logic [7:0] DATE_ONE = 8'h01;

  // counter limits in bcd
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] WEEKDAY_LAST = 8'h06;

  // one full set of timekeeping counters
  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] days;
    logic [7:0] weekdays;
    logic [7:0] months;
    logic [7:0] years;
  } time_t;

  // bcd increment of a two digit value, no limit check
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      r = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
    return r;
  endfunction

  // last day of a bcd month, leap when the bcd year divides by four
  function automatic logic [7:0] month_last_day(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    logic [7:0] r;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: r = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

endpackage

// file: src/time_counter.sv
// bcd timekeeping counters, seconds through years, with host write access
`timescale 1ns/100ps
`default_nettype none
module time_counter
  import cal_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // control
  input wire logic i_advance,
  input wire logic i_hour_12_mode,
  // host write port
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  // current time
  output time_t o_time
);

  time_t time_q;
  time_t next_t;
  logic c_min, c_hour, c_day, c_mon, c_year;
  logic [7:0] hr12;

  // carry chain of one second step
  always_comb begin
    next_t = time_q;
    c_min = (time_q.seconds == BCD_59);
    c_hour = c_min && (time_q.minutes == BCD_59);
    hr12 = {3'b000, time_q.hours[4:0]};
    if (i_hour_12_mode) begin
      c_day = c_hour && (hr12 == BCD_11) && time_q.hours[AFTERNOON_BIT];
    end else begin
      c_day = c_hour && (time_q.hours == BCD_23);
    end
    c_mon = c_day && (time_q.days == month_last_day(time_q.months, time_q.years));
    c_year = c_mon && (time_q.months == BCD_12);
    next_t.seconds = c_min ? TIME_ZERO : bcd_inc(time_q.seconds);
    if (c_min) begin
      next_t.minutes = c_hour ? TIME_ZERO : bcd_inc(time_q.minutes);
    end
    if (c_hour) begin
      if (!i_hour_12_mode) begin
        next_t.hours = c_day ? TIME_ZERO : bcd_inc(time_q.hours);
      end else if (hr12 == BCD_12) begin
        next_t.hours = {time_q.hours[7:5], DATE_ONE[4:0]};
      end else if (hr12 == BCD_11) begin
        // eleven to twelve flips the afternoon half
        next_t.hours = {time_q.hours[7:6], ~time_q.hours[AFTERNOON_BIT], BCD_12[4:0]};
      end else begin
        next_t.hours = {time_q.hours[7:5], 5'(bcd_inc(hr12))};
      end
    end
    if (c_day) begin
      next_t.days = c_mon ? DATE_ONE : bcd_inc(time_q.days);
      next_t.weekdays = (time_q.weekdays == WEEKDAY_LAST) ? TIME_ZERO : time_q.weekdays + 8'h01;
    end
    if (c_mon) begin
      next_t.months = c_year ? DATE_ONE : bcd_inc(time_q.months);
    end
    if (c_year) begin
      next_t.years = (time_q.years == BCD_99) ? TIME_ZERO : bcd_inc(time_q.years);
    end
  end

  // counters: host writes take precedence over a step in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      time_q <= '{TIME_ZERO, TIME_ZERO, TIME_ZERO, DATE_ONE, TIME_ZERO, DATE_ONE, TIME_ZERO};
    end else if (i_wr_en) begin
      case (i_wr_addr)
        ADDR_SECONDS: time_q.seconds <= i_wr_data & MASK_SECONDS;
        ADDR_MINUTES: time_q.minutes <= i_wr_data & MASK_MINUTES;
        ADDR_HOURS: time_q.hours <= i_wr_data & MASK_HOURS;
        ADDR_DAYS: time_q.days <= i_wr_data & MASK_DAYS;
        ADDR_WEEKDAYS: time_q.weekdays <= i_wr_data & MASK_WEEKDAYS;
        ADDR_MONTHS: time_q.months <= i_wr_data & MASK_MONTHS;
        ADDR_YEARS: time_q.years <= i_wr_data & MASK_YEARS;
        default: time_q <= i_advance ? next_t : time_q;
      endcase
    end else if (i_advance) begin
      time_q <= next_t;
    end
  end

  assign o_time = time_q;

endmodule
`default_nettype wire

// file: src/alarm_match.sv
// compares the enabled alarm fields with the current time
`timescale 1ns/100ps
`default_nettype none
module alarm_match
  import cal_pkg::*;
(
  // alarm settings
  input wire logic [7:0] i_alarm_minute,
  input wire logic [7:0] i_alarm_hour,
  input wire logic [7:0] i_alarm_day,
  input wire logic [7:0] i_alarm_weekday,
  // current time
  input wire time_t i_time,
  // result
  output logic o_match
);

  logic minute_match_disable, hour_match_disable, day_match_disable, weekday_match_disable;
  logic m_ok, h_ok, d_ok, w_ok;

  // a field counts only while its disable bit is low
  always_comb begin
    minute_match_disable = i_alarm_minute[MATCH_DISABLE_BIT];
    hour_match_disable = i_alarm_hour[MATCH_DISABLE_BIT];
    day_match_disable = i_alarm_day[MATCH_DISABLE_BIT];
    weekday_match_disable = i_alarm_weekday[MATCH_DISABLE_BIT];
    m_ok = minute_match_disable || (i_alarm_minute[6:0] == i_time.minutes[6:0]);
    // bits 5..0 carry the afternoon bit in 12 hour form and the tens pair in 24 hour form
    h_ok = hour_match_disable || (i_alarm_hour[5:0] == i_time.hours[5:0]);
    d_ok = day_match_disable || (i_alarm_day[5:0] == i_time.days[5:0]);
    w_ok = weekday_match_disable || (i_alarm_weekday[2:0] == i_time.weekdays[2:0]);
    // with every field disabled there is nothing to match
    o_match = m_ok && h_ok && d_ok && w_ok
              && !(minute_match_disable && hour_match_disable
                   && day_match_disable && weekday_match_disable);
  end

endmodule
`default_nettype wire

// file: test/host_model.sv
// host side model: byte reads and writes framed by a transfer window
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock and read data
  input wire logic i_mclk,
  input wire logic [7:0] i_rd_data,
  // transfer window and strobes
  output var logic o_xfer,
  output var logic o_wr_en,
  output var logic [7:0] o_wr_addr,
  output var logic [7:0] o_wr_data,
  output var logic o_rd_en,
  output var logic [7:0] o_rd_addr
);
  // idle bus at time zero
  initial begin
    {o_xfer, o_wr_en, o_rd_en} = 3'h0;
    {o_wr_addr, o_wr_data, o_rd_addr} = 24'h0;
  end

  // a frame stays open until the caller closes it, and may span several ticks
  task automatic frame(input logic on);
    @(posedge i_mclk) #1 o_xfer = on;
  endtask

  // released lines are inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk) #1 {o_wr_en, o_wr_addr, o_wr_data} = {1'b1, a, d};
    @(posedge i_mclk) #1 {o_wr_en, o_wr_addr, o_wr_data} = {1'b0, ~a, ~d};
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk) #1 {o_rd_en, o_rd_addr} = {1'b1, a};
    @(posedge i_mclk) #1 {o_rd_en, o_rd_addr} = {1'b0, ~a};
    d = i_rd_data;
  endtask
endmodule
`default_nettype wire

// file: test/cal_alarm_chk.sv
// concurrent checks on the access interlock, flag register and interrupt pin
`timescale 1ns/100ps
`default_nettype none
module cal_alarm_chk
  import cal_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // inputs
  input wire logic i_sec_tick,
  input wire logic i_xfer_active,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_alarm_irq_enable,
  input wire logic i_watchdog_timer_set,
  input wire logic i_countdown_a_set,
  input wire logic i_countdown_b_set,
  input wire logic i_second_tick_set,
  // outputs
  input wire logic o_irq_out_first_oe,
  input wire time_t o_time,
  input wire logic [7:0] o_flag_status,
  input wire logic o_tick_pending
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  // flag register write and set events, bit order 7..4
  logic flag_wr;
  logic [3:0] set_ev;
  assign flag_wr = i_wr_en && i_wr_addr == ADDR_FLAG_STATUS;
  assign set_ev = {i_watchdog_timer_set, i_countdown_a_set, i_countdown_b_set, i_second_tick_set};

  property p_freeze;
    i_xfer_active && !i_wr_en |=> o_time == $past(o_time);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("time moved during a transfer");

  property p_hold;
    i_xfer_active && i_sec_tick |=> o_tick_pending;
  endproperty
  a_hold: assert property (p_hold)
    else $error("tick during transfer not held");

  property p_apply;
    o_tick_pending && !i_xfer_active && !i_wr_en
      |=> !o_tick_pending && o_time.seconds != $past(o_time.seconds);
  endproperty
  a_apply: assert property (p_apply)
    else $error("held tick not applied at release");

  property p_irq;
    o_irq_out_first_oe == (i_alarm_irq_enable && o_flag_status[ALARM_FLAG_BIT]);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt pin does not follow alarm flag");

  property p_sticky;
    o_flag_status[3] && !(flag_wr && !i_wr_data[3]) |=> o_flag_status[3];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("alarm flag dropped without a clear");

  property p_clear;
    flag_wr && !i_wr_data[7] && !i_watchdog_timer_set |=> !o_flag_status[7];
  endproperty
  a_clear: assert property (p_clear)
    else $error("zero write did not clear flag");

  property p_keep;
    flag_wr |=> (~o_flag_status[7:3] & $past(o_flag_status[7:3] & i_wr_data[7:3])) == 5'h00;
  endproperty
  a_keep: assert property (p_keep)
    else $error("one write lost a flag");

  property p_set;
    |set_ev |=> (o_flag_status[7:4] & $past(set_ev)) == $past(set_ev);
  endproperty
  a_set: assert property (p_set)
    else $error("set event missed its flag bit");

  property p_rise;
    $rose(o_flag_status[3]) |-> $past(o_time) != $past(o_time, 2);
  endproperty
  a_rise: assert property (p_rise)
    else $error("alarm flag rose without a time step");

  // main scenarios reached
  c_held: cover property (o_tick_pending ##1 !o_tick_pending);
  c_alarm: cover property ($rose(o_flag_status[3]));
  c_irq_drop: cover property ($fell(o_irq_out_first_oe));
endmodule

bind calendar_access_and_alarm cal_alarm_chk i_chk (
  .i_mclk, .i_reset, .i_sec_tick, .i_xfer_active, .i_wr_en, .i_wr_addr, .i_wr_data,
  .i_alarm_irq_enable, .i_watchdog_timer_set, .i_countdown_a_set, .i_countdown_b_set,
  .i_second_tick_set, .o_irq_out_first_oe, .o_time, .o_flag_status, .o_tick_pending
);
`default_nettype wire

// file: test/calendar_access_and_alarm_bench.sv
// self-checking bench for the access interlock, alarm flag and interrupt
`timescale 1ns/100ps
`default_nettype none
module calendar_access_and_alarm_bench;
  import cal_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset;
  logic i_sec_tick;
  logic i_hour_12_mode;
  logic i_alarm_irq_enable;
  logic [3:0] ev;
  logic i_xfer_active, i_wr_en, i_rd_en;
  logic [7:0] i_wr_addr, i_wr_data, i_rd_addr, o_rd_data, o_flag_status;
  logic o_irq_out_first_o, o_irq_out_first_oe, o_tick_pending;
  time_t o_time;
  int n_fail = 0;
  int cmp_count = 0;

  always #12.5 i_mclk = ~i_mclk;

  calendar_access_and_alarm i_calendar_access_and_alarm (
    .i_mclk, .i_reset, .i_sec_tick, .i_xfer_active, .i_wr_en, .i_wr_addr, .i_wr_data,
    .i_rd_en, .i_rd_addr, .o_rd_data, .i_hour_12_mode, .i_alarm_irq_enable,
    .i_watchdog_timer_set(ev[3]), .i_countdown_a_set(ev[2]), .i_countdown_b_set(ev[1]),
    .i_second_tick_set(ev[0]), .o_irq_out_first_o, .o_irq_out_first_oe, .o_time,
    .o_flag_status, .o_tick_pending
  );

  host_model i_host_model (
    .i_mclk, .i_rd_data(o_rd_data), .o_xfer(i_xfer_active), .o_wr_en(i_wr_en),
    .o_wr_addr(i_wr_addr), .o_wr_data(i_wr_data), .o_rd_en(i_rd_en), .o_rd_addr(i_rd_addr)
  );

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host_model.rd(a, d);
    chk("read data", exp, d);
  endtask

  // one second tick, one cycle wide
  task automatic tick();
    @(posedge i_mclk) #1 i_sec_tick = 1'b1;
    @(posedge i_mclk) #1 i_sec_tick = 1'b0;
  endtask

  // alarm reset values, unused bits read zero, unmapped address reads zero
  task automatic t_regs();
    logic [7:0] a[4] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] m[4] = '{8'hff, 8'hbf, 8'hbf, 8'h87};
    for (int k = 0; k < 4; k++) begin
      chk_rd(a[k], 8'h80);
      i_host_model.wr(a[k], 8'hff);
      chk_rd(a[k], m[k]);
    end
    chk_rd(8'h20, 8'h00);
    chk_rd(8'h01, 8'h00);
  endtask

  // two ticks inside one frame: counters hold, only one step survives
  task automatic t_freeze();
    i_host_model.frame(1'b1);
    tick();
    tick();
    chk_rd(8'h03, 8'h00);
    chk("held tick", 8'h01, {7'h0, o_tick_pending});
    i_host_model.frame(1'b0);
    repeat (2) @(posedge i_mclk);
    chk_rd(8'h03, 8'h01);
  endtask

  // day alarm stays disabled and mismatching, so it must be ignored
  task automatic t_alarm();
    logic [7:0] tv[7] = '{8'h00, 8'h30, 8'h10, 8'h05, 8'h03, 8'h01, 8'h24};
    logic [7:0] d;
    i_host_model.frame(1'b1);
    i_host_model.wr(8'h0a, 8'h30);
    i_host_model.wr(8'h0b, 8'h10);
    i_host_model.wr(8'h0d, 8'h03);
    for (int k = 0; k < 7; k++) i_host_model.wr(8'(k + 3), tv[k]);
    i_host_model.frame(1'b0);
    repeat (3) @(posedge i_mclk);
    chk("flag after time write", 8'h00, o_flag_status);
    i_host_model.frame(1'b1);
    i_host_model.wr(8'h03, 8'h59);
    i_host_model.wr(8'h04, 8'h29);
    i_host_model.frame(1'b0);
    tick();
    repeat (2) @(posedge i_mclk);
    #1 chk("flag on match", 8'h08, o_flag_status);
    chk("irq pin", 8'h01, {7'h0, o_irq_out_first_oe});
    i_host_model.frame(1'b1);
    i_host_model.rd(8'h01, d);
    i_host_model.wr(8'h01, d & 8'hf7);
    chk("irq after clear", 8'h00, {7'h0, o_irq_out_first_oe});
    i_host_model.frame(1'b0);
    tick();
    repeat (2) @(posedge i_mclk);
    #1 chk("flag on held match", 8'h00, o_flag_status);
  endtask

  // all set events at once, then an and-write that keeps two of them
  task automatic t_flags();
    @(posedge i_mclk) #1 ev = 4'hf;
    @(posedge i_mclk) #1 ev = 4'h0;
    chk_rd(8'h01, 8'hf0);
    i_host_model.wr(8'h01, 8'h6b);
    chk_rd(8'h01, 8'h63);
  endtask

  // 12 hour form: 11:59:58 am steps twice to 12 pm; the alarm fires with the pin masked
  task automatic t_hour12();
    @(posedge i_mclk) #1 i_hour_12_mode = 1'b1;
    i_alarm_irq_enable = 1'b0;
    i_host_model.frame(1'b1);
    i_host_model.wr(8'h0a, 8'h00);
    i_host_model.wr(8'h0b, 8'h32);
    i_host_model.wr(8'h0d, 8'h80);
    i_host_model.wr(8'h03, 8'h58);
    i_host_model.wr(8'h04, 8'h59);
    i_host_model.wr(8'h05, 8'h11);
    i_host_model.frame(1'b0);
    tick();
    repeat (2) @(posedge i_mclk);
    #1 chk("flag before match", 8'h63, o_flag_status);
    tick();
    repeat (2) @(posedge i_mclk);
    #1 chk("flag on 12 hour match", 8'h6b, o_flag_status);
    chk("irq pin masked", 8'h00, {7'h0, o_irq_out_first_oe});
    chk("time hours", 8'h32, o_time.hours);
    @(posedge i_mclk) #1 i_alarm_irq_enable = 1'b1;
    #1 chk("irq pin unmasked", 8'h01, {7'h0, o_irq_out_first_oe});
    chk("irq pin level", 8'h00, {7'h0, o_irq_out_first_o});
    i_host_model.wr(8'h01, 8'h63);
    chk("irq after second clear", 8'h00, {7'h0, o_irq_out_first_oe});
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    i_reset = 1'b1;
    i_sec_tick = 1'b0;
    i_hour_12_mode = 1'b0;
    i_alarm_irq_enable = 1'b1;
    ev = 4'h0;
    repeat (10) @(posedge i_mclk);
    #1 i_reset = 1'b0;
    t_regs();
    t_freeze();
    t_alarm();
    t_flags();
    t_hour12();
    give_verdict();
  end

  // tests need about 130 cycles; 4000 cycles means a hang
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
